// File: design/mbhs_pkg.sv
/*
  constants, offsets and layouts for the inbound mailbox handshake block.
  assumes a single 10 MHz core clock and an avalon-mm register bus.
*/
package mbhs_pkg;
  // input image word offsets
  localparam logic [7:0]  IMG_QCOUNT_OFS  = 8'h49;   // 73
  localparam logic [7:0]  IMG_INDEX_OFS   = 8'h4D;   // 77
  localparam logic [7:0]  IMG_MSG_FIRST   = 8'h4F;   // 79
  localparam logic [7:0]  IMG_MSG_LAST    = 8'hDE;   // 222
  localparam int          MSG_WORDS       = 144;
  localparam logic [7:0]  MSG_LAST_WORD   = 8'h8F;   // 143
  // message header word positions relative to the area start
  localparam logic [7:0]  HDR_ID          = 8'h00;   // 79
  localparam logic [7:0]  HDR_INFO        = 8'h01;   // 80
  localparam logic [7:0]  HDR_CMD         = 8'h02;   // 81
  localparam logic [7:0]  HDR_SIZE        = 8'h03;   // 82
  localparam logic [7:0]  HDR_EXT_FIRST   = 8'h08;   // 87
  localparam logic [7:0]  HDR_EXT_LAST    = 8'h0F;   // 94
  // status word fields
  localparam int          STW_ERR_BIT     = 7;
  localparam int          STW_CR_BIT      = 6;
  localparam logic [15:0] STW_RSVD_MASK   = 16'h0030;
  localparam logic [15:0] STW_CODE_MASK   = 16'h000F;
  localparam int          STW_TYPE_LSB    = 12;
  // error codes
  localparam logic [3:0]  ERR_BAD_ID      = 4'h0;
  localparam logic [3:0]  ERR_BAD_TYPE    = 4'h1;
  localparam logic [3:0]  ERR_BAD_CMD     = 4'h2;
  localparam logic [3:0]  ERR_BAD_SIZE    = 4'h3;
  localparam logic [3:0]  ERR_HDR_A       = 4'h4;
  localparam logic [3:0]  ERR_HDR_B       = 4'h5;
  localparam logic [3:0]  ERR_HDR_C       = 4'h6;
  localparam logic [3:0]  ERR_BAD_RSP     = 4'h8;
  localparam logic [3:0]  ERR_FLASH       = 4'h9;
  localparam logic [3:0]  ERR_OTHER       = 4'hF;
  // message types
  localparam logic [3:0]  TYPE_APP        = 4'h1;
  localparam logic [3:0]  TYPE_FIELDBUS   = 4'h2;
  localparam logic [3:0]  TYPE_MEMORY     = 4'h3;
  localparam logic [3:0]  TYPE_RESET      = 4'h5;
  // queue geometry
  localparam int          Q_SLOTS         = 4;
  localparam int          Q_WORDS         = Q_SLOTS * MSG_WORDS;
  // register byte addresses
  localparam logic [11:0] REG_CTRL        = 12'h000;
  localparam logic [11:0] REG_STATE       = 12'h004;
  localparam logic [11:0] REG_IRQ_STAT    = 12'h008;
  localparam logic [11:0] REG_IRQ_MASK    = 12'h00C;
  localparam logic [11:0] REG_MSG_STATUS  = 12'h010;
  localparam logic [11:0] REG_STAGE_BASE  = 12'h400;
  localparam logic [11:0] REG_STAGE_LAST  = 12'h63C;
  // irq bits and reset values
  localparam int          IRQ_DELIVERED   = 0;
  localparam int          IRQ_ACKED       = 1;
  localparam int          IRQ_REFUSED     = 2;
  localparam logic [2:0]  IRQ_RESET       = 3'h0;
  localparam logic [15:0] INDEX_RESET     = 16'h0000;
  localparam logic [15:0] STATUS_RESET    = 16'h0000;
  typedef enum {ST_IDLE, ST_COPY} mbhs_state_t;
endpackage

// File: design/mbhs_q_if.sv
/*
  carrier between the mailbox handshake top and its message queue.
  assumes both ends run on the same core clock.
*/
interface mbhs_q_if;
  logic       push;
  logic       pop;
  logic       stg_we;
  logic [7:0] stg_word;
  logic [15:0] stg_wdata;
  logic [15:0] stg_rdata;
  logic [7:0] rd_word;
  logic [15:0] rd_data;
  logic [2:0] count;
  logic       full;
  logic       empty;
  modport ctl (output push, output pop, output stg_we, output stg_word, output stg_wdata,
               input stg_rdata, output rd_word, input rd_data, input count, input full, input empty);
  modport q   (input push, input pop, input stg_we, input stg_word, input stg_wdata,
               output stg_rdata, input rd_word, output rd_data, output count, output full, output empty);
endinterface

// File: design/mbhs_queue.sv
/*
  ring of whole-message slots; software stages a message in the tail slot and
  pushes it, the delivery engine reads the head slot and pops it.
  assumes the caller never pushes when full nor pops when empty.
*/
module mbhs_queue (
  input  wire logic core_clk,
  input  wire logic reset_n,
  mbhs_q_if.q       qi
);
  logic [15:0] mem [mbhs_pkg::Q_WORDS];
  logic [1:0]  head;
  logic [1:0]  tail;
  logic [2:0]  count;
  logic [1:0]  next_head;
  logic [1:0]  next_tail;
  logic [2:0]  next_count;
  logic [9:0]  wr_addr;
  logic [9:0]  rd_addr;

  assign wr_addr = 10'(tail * mbhs_pkg::MSG_WORDS) + 10'(qi.stg_word);
  assign rd_addr = 10'(head * mbhs_pkg::MSG_WORDS) + 10'(qi.rd_word);
  assign qi.stg_rdata = mem[wr_addr];
  assign qi.rd_data   = mem[rd_addr];
  assign qi.count     = count;
  assign qi.full      = (count == 3'(mbhs_pkg::Q_SLOTS));
  assign qi.empty     = (count == 3'h0);

  always_comb begin
    next_head  = head;
    next_tail  = tail;
    next_count = count;
    if (qi.push) begin
      next_tail = tail + 2'h1;
    end
    if (qi.pop) begin
      next_head = head + 2'h1;
    end
    // simultaneous push and pop leaves the count alone
    if (qi.push && !qi.pop) begin
      next_count = count + 3'h1;
    end else if (qi.pop && !qi.push) begin
      next_count = count - 3'h1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      head  <= 2'h0;
      tail  <= 2'h0;
      count <= 3'h0;
    end else begin
      head  <= next_head;
      tail  <= next_tail;
      count <= next_count;
    end
  end

  // storage has no reset; only staged words are ever delivered
  always_ff @(posedge core_clk) begin
    if (qi.stg_we) begin
      mem[wr_addr] <= qi.stg_wdata;
    end
  end
endmodule // mbhs_queue

// File: design/mbhs_top.sv
/*
  inbound mailbox handshake: delivers queued messages into the mailbox area of
  the cyclic input image and steps the inbound index on each delivered message.
  assumes host_index comes from another clock and is synchronised here; the
  image read port and the avalon-mm slave run on core_clk.
*/
// The Avalon-MM register port and the placing of the registers were decided locally.
// Functional notes
// - equal indices load next message, bump index
// - messages live only in words 79..222
// - word 79 echoes the host message identifier
// - header words 80..94, then command data
// - status bit 7 flags erroneous command
// - status bit 6: 0 response, 1 command
// - bits 3..0 carry the error code
// - upper status bits carry message type
// - index at word 77, queue count 73
// - responses return through the input image
module mbhs_top (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [15:0] host_index,
  input  wire logic [7:0]  img_addr,
  output logic      [15:0] img_data,
  output logic             irq
);
  mbhs_q_if qi ();

  mbhs_queue u_queue (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .qi       (qi.q)
  );

  // host index crossing
  logic [15:0] host_idx_meta;
  logic [15:0] host_idx_sync;
  logic [15:0] host_idx_prev;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      host_idx_meta <= mbhs_pkg::INDEX_RESET;
      host_idx_sync <= mbhs_pkg::INDEX_RESET;
      host_idx_prev <= mbhs_pkg::INDEX_RESET;
    end else begin
      host_idx_meta <= host_index;
      host_idx_sync <= host_idx_meta;
      host_idx_prev <= host_idx_sync;
    end
  end

  // delivery engine
  mbhs_pkg::mbhs_state_t state;
  mbhs_pkg::mbhs_state_t next_state;
  logic [15:0] in_index;
  logic [15:0] next_in_index;
  logic [7:0]  copy_word;
  logic [7:0]  next_copy_word;
  logic [15:0] msg_status;
  logic [15:0] next_msg_status;
  logic [15:0] image [mbhs_pkg::MSG_WORDS];
  logic        img_we;
  logic [15:0] img_wdata;
  logic        delivered;
  logic        host_acked;

  logic        start_copy;
  logic        copy_info;
  logic        copy_last;

  assign host_acked = (host_idx_sync != host_idx_prev) && (host_idx_sync == in_index);
  // a lagging host or an empty queue holds the engine idle
  assign start_copy = (in_index == host_idx_sync) && !qi.empty;
  // header word 80 is where the reserved bits get cleaned
  assign copy_info  = (copy_word == mbhs_pkg::HDR_INFO);
  assign copy_last  = (copy_word == mbhs_pkg::MSG_LAST_WORD);

  always_comb begin
    next_state      = state;
    next_in_index   = in_index;
    next_copy_word  = copy_word;
    next_msg_status = msg_status;
    img_we          = 1'b0;
    img_wdata       = qi.rd_data;
    delivered       = 1'b0;
    qi.pop          = 1'b0;
    case (state)
      mbhs_pkg::ST_IDLE: begin
        // nothing moves while the queue is empty or the host lags
        if (start_copy) begin
          next_state     = mbhs_pkg::ST_COPY;
          next_copy_word = 8'h00;
        end
      end
      mbhs_pkg::ST_COPY: begin
        // id, header except word 80, extended words and data copied verbatim
        img_we = 1'b1;
        if (copy_info) begin
          // error, direction, code and type pass as queued
          img_wdata       = qi.rd_data & ~mbhs_pkg::STW_RSVD_MASK;
          next_msg_status = img_wdata;
        end
        next_copy_word = copy_word + 8'h01;
        if (copy_last) begin
          // index steps only once the whole message sits in the image
          next_in_index = in_index + 16'h0001;
          qi.pop        = 1'b1;
          delivered     = 1'b1;
          next_state    = mbhs_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = mbhs_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= mbhs_pkg::ST_IDLE;
      in_index   <= mbhs_pkg::INDEX_RESET;
      copy_word  <= 8'h00;
      msg_status <= mbhs_pkg::STATUS_RESET;
    end else begin
      state      <= next_state;
      in_index   <= next_in_index;
      copy_word  <= next_copy_word;
      msg_status <= next_msg_status;
    end
  end

  assign qi.rd_word = copy_word;

  // message words carry no reset; the host trusts them only once the index steps
  always_ff @(posedge core_clk) begin
    if (img_we) begin
      image[copy_word] <= img_wdata;
    end
  end

  // image read port; only this block's words answer
  logic [15:0] next_img_data;
  logic [7:0]  img_rel;
  logic        img_sel_count;
  logic        img_sel_index;
  logic        img_sel_msg;

  assign img_rel       = img_addr - mbhs_pkg::IMG_MSG_FIRST;
  assign img_sel_count = (img_addr == mbhs_pkg::IMG_QCOUNT_OFS);
  assign img_sel_index = (img_addr == mbhs_pkg::IMG_INDEX_OFS);
  // words 78 and 223 fall outside and read zero
  assign img_sel_msg   = (img_addr >= mbhs_pkg::IMG_MSG_FIRST) && (img_addr <= mbhs_pkg::IMG_MSG_LAST);

  always_comb begin
    next_img_data = 16'h0000;
    if (img_sel_count) begin
      next_img_data = {13'h0000, qi.count};
    end else if (img_sel_index) begin
      next_img_data = in_index;
    end else if (img_sel_msg) begin
      next_img_data = image[img_rel];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      img_data <= 16'h0000;
    end else begin
      img_data <= next_img_data;
    end
  end

  // avalon slave: one wait state, then a single answer cycle
  logic [2:0]  irq_stat;
  logic [2:0]  irq_mask;
  logic [2:0]  next_irq_stat;
  logic [2:0]  next_irq_mask;
  logic [31:0] next_readdata;
  logic        next_waitrequest;
  logic        next_irq;
  logic        take;
  logic        wr_any;
  logic        in_stage;
  logic        refused;
  logic [11:0] stage_ofs;
  // one decode per register keeps reads and writes in step
  logic        sel_ctrl;
  logic        sel_state;
  logic        sel_stat;
  logic        sel_mask;
  logic        sel_msg;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_mask;
  logic [31:0] rd_mux;

  assign take      = avs_waitrequest && (avs_read || avs_write);
  assign wr_any    = take && avs_write && (avs_byteenable != 4'h0);
  assign in_stage  = (avs_address >= mbhs_pkg::REG_STAGE_BASE) && (avs_address <= mbhs_pkg::REG_STAGE_LAST);
  assign stage_ofs = avs_address - mbhs_pkg::REG_STAGE_BASE;
  assign qi.stg_word  = stage_ofs[9:2];
  assign qi.stg_wdata = avs_writedata[15:0];

  // register selects, shared by the read mux and the write strobes
  assign sel_ctrl  = (avs_address == mbhs_pkg::REG_CTRL);
  assign sel_state = (avs_address == mbhs_pkg::REG_STATE);
  assign sel_stat  = (avs_address == mbhs_pkg::REG_IRQ_STAT);
  assign sel_mask  = (avs_address == mbhs_pkg::REG_IRQ_MASK);
  assign sel_msg   = (avs_address == mbhs_pkg::REG_MSG_STATUS);
  assign wr_ctrl   = wr_any && sel_ctrl;
  assign wr_stat   = wr_any && sel_stat;
  assign wr_mask   = wr_any && sel_mask;

  // unmapped offsets and the upper half of every register except REG_STATE read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_state) begin
      rd_mux = {host_idx_sync, in_index[12:0], qi.count};
    end else if (sel_stat) begin
      rd_mux = {29'h0000_0000, irq_stat};
    end else if (sel_mask) begin
      rd_mux = {29'h0000_0000, irq_mask};
    end else if (sel_msg) begin
      rd_mux = {16'h0000, msg_status};
    end else if (in_stage) begin
      rd_mux = {16'h0000, qi.stg_rdata};
    end
  end

  always_comb begin
    qi.stg_we = 1'b0;
    qi.push   = 1'b0;
    refused   = 1'b0;
    // staging slot is locked out only while the queue is full
    if (wr_any && in_stage && !qi.full) begin
      qi.stg_we = 1'b1;
    end
    if (wr_ctrl && avs_writedata[0]) begin
      if (qi.full) begin
        refused = 1'b1;
      end else begin
        qi.push = 1'b1;
      end
    end
  end

  always_comb begin
    next_waitrequest = 1'b1;
    next_readdata    = avs_readdata;
    next_irq_mask    = irq_mask;
    next_irq_stat    = irq_stat;
    if (take) begin
      next_waitrequest = 1'b0;
      next_readdata    = 32'h0000_0000;
      if (avs_read) begin
        next_readdata = rd_mux;
      end
      if (wr_mask) begin
        next_irq_mask = avs_writedata[2:0];
      end
      if (wr_stat) begin
        next_irq_stat = irq_stat & ~avs_writedata[2:0];
      end
    end
    // events after the clear so a same-cycle event survives
    if (delivered) begin
      next_irq_stat[mbhs_pkg::IRQ_DELIVERED] = 1'b1;
    end
    if (host_acked) begin
      next_irq_stat[mbhs_pkg::IRQ_ACKED] = 1'b1;
    end
    if (refused) begin
      next_irq_stat[mbhs_pkg::IRQ_REFUSED] = 1'b1;
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      irq_stat        <= mbhs_pkg::IRQ_RESET;
      irq_mask        <= mbhs_pkg::IRQ_RESET;
      irq             <= 1'b0;
    end else begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata    <= next_readdata;
      irq_stat        <= next_irq_stat;
      irq_mask        <= next_irq_mask;
      irq             <= next_irq;
    end
  end
endmodule // mbhs_top

// File: testbench/mbhs_top_sva.sv
/* port checker for the inbound mailbox handshake top.
   assumes one core clock and the active-low async reset. */
module mbhs_top_sva (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [15:0] host_index,
  input wire logic [7:0]  img_addr,
  input wire logic [15:0] img_data,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_ans; !avs_waitrequest ##1 avs_waitrequest; endsequence
  property p_answer; s_req |=> s_ans; endproperty
  property p_fell; $fell(avs_waitrequest) |-> $past(avs_read || avs_write); endproperty
  property p_unmapped;
    s_req and (avs_read && avs_address > 12'h010 && avs_address < 12'h400) |=> avs_readdata == 32'h00000000;
  endproperty
  property p_stat_reg;
    s_req and (avs_read && avs_address == 12'h010) |=> avs_readdata[31:16] == 16'h0000 && avs_readdata[5:4] == 2'h0;
  endproperty
  property p_outside;
    !(img_addr == 8'h49 || img_addr == 8'h4D || (img_addr >= 8'h4F && img_addr <= 8'hDE)) |=> img_data == 16'h0000;
  endproperty
  property p_rsvd; img_addr == 8'h50 |=> img_data[5:4] == 2'h0; endproperty
  property p_step;
    $past(img_addr) == 8'h4D && $past(img_addr, 2) == 8'h4D && img_data != $past(img_data)
      |-> img_data == $past(img_data) + 16'h0001;
  endproperty
  property p_count; img_addr == 8'h49 |=> img_data <= 16'h0004; endproperty
  a_answer:   assert property (p_answer) else $error("bus answer not one cycle");
  a_fell:     assert property (p_fell) else $error("answer without request");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_stat_reg: assert property (p_stat_reg) else $error("status register bits wrong");
  a_outside:  assert property (p_outside) else $error("word outside area not zero");
  a_rsvd:     assert property (p_rsvd) else $error("reserved status bits set");
  a_step:     assert property (p_step) else $error("index stepped by other than one");
  a_count:    assert property (p_count) else $error("queue count above depth");
endmodule // mbhs_top_sva
bind mbhs_top mbhs_top_sva u_sva (.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .host_index(host_index),
  .img_addr(img_addr), .img_data(img_data), .irq(irq));

// File: testbench/mbhs_host_model.sv
/* host controller model: reads the input image, acknowledges by copying the index.
   assumes img_data answers one edge after img_addr. */
module mbhs_host_model (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        auto_ack,
  input  wire logic [7:0]  peek_addr,
  input  wire logic [15:0] img_data,
  output logic      [7:0]  img_addr,
  output logic      [15:0] host_index
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ack_seen;
  assign img_addr = auto_ack ? 8'h4D : peek_addr;
  // wait one edge so img_data shows word 77, not the old peek
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_seen   <= 1'b0;
      host_index <= 16'h0000;
    end else begin
      ack_seen <= auto_ack;
      if (auto_ack && ack_seen) host_index <= img_data;
    end
  end
endmodule // mbhs_host_model

// File: testbench/incoming_mailbox_handshake_tb.sv
/* self-checking bench for the inbound mailbox handshake top.
   assumes the host model and the bound port checker. */
module incoming_mailbox_handshake_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [15:0] stw; logic [15:0] exp;} mbhs_row_t;
  // every error code and message type, reserved bits staged as one
  mbhs_row_t rows [12] = '{'{16'h10B0, 16'h1080}, '{16'h20F1, 16'h20C1}, '{16'h30B2, 16'h3082},
    '{16'h50F3, 16'h50C3}, '{16'h10B4, 16'h1084}, '{16'h20F5, 16'h20C5}, '{16'h30B6, 16'h3086},
    '{16'h50F8, 16'h50C8}, '{16'h10B9, 16'h1089}, '{16'h20FF, 16'h20CF}, '{16'h3070, 16'h3040},
    '{16'h5030, 16'h5000}};
  logic        core_clk = 0, reset_n = 0, avs_read = 0, avs_write = 0, auto_ack = 0, irq, avs_waitrequest;
  logic [11:0] avs_address = 12'h000;
  logic [31:0] avs_writedata = 32'h00000000, avs_readdata, rd;
  logic [7:0]  peek_addr = 8'h4D, img_addr;
  logic [15:0] img_data, host_index;
  int          errors = 0, cmp_count = 0, cyc = 0;
  mbhs_top dut (.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .host_index(host_index), .img_addr(img_addr), .img_data(img_data), .irq(irq));
  mbhs_host_model host (.core_clk(core_clk), .reset_n(reset_n), .auto_ack(auto_ack), .peek_addr(peek_addr),
    .img_data(img_data), .img_addr(img_addr), .host_index(host_index));
  always #50 core_clk = ~core_clk;
  task automatic wrap_up;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // no fixed latency assumed: hold until waitrequest is seen low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic peek(input logic [7:0] a, input logic [15:0] e, input string nm);
    peek_addr <= a;
    repeat (2) @(posedge core_clk);
    chk(nm, {16'h0000, e}, {16'h0000, img_data});
  endtask
  task automatic push_wait(input int n);
    bus(1'b1, mbhs_pkg::REG_CTRL, 32'h00000001, rd);
    for (int t = 0; t < n && irq !== 1'b1; t++) @(posedge core_clk);
  endtask
  task automatic ack(input int n);
    auto_ack <= 1'b1;
    repeat (n) @(posedge core_clk);
    auto_ack <= 1'b0;
    @(posedge core_clk);
  endtask
  function automatic logic [15:0] wd(input int i, input int k, input logic [15:0] s);
    return (k == 0) ? 16'hA000 + 16'(i) : (k == 1) ? s : {8'(i), 8'(k)};
  endfunction
  initial begin
    repeat (10) @(posedge core_clk);
    chk("rst_wait", 32'h1, {31'h0, avs_waitrequest});
    chk("rst_out", 32'h0, {irq, avs_readdata[30:0]} | {16'h0, img_data});
    reset_n <= 1'b1;
    @(posedge core_clk);
    bus(1'b0, mbhs_pkg::REG_IRQ_MASK, 32'h0, rd);
    chk("mask_rst", 32'h0, rd);
    bus(1'b1, mbhs_pkg::REG_IRQ_MASK, 32'h1, rd);
    foreach (rows[i]) begin
      for (int k = 0; k < 144; k++) bus(1'b1, 12'h400 + 12'(4 * k), {16'h0, wd(i, k, rows[i].stw)}, rd);
      push_wait(300);
      chk("irq_set", 32'h1, {31'h0, irq});
      for (int k = 0; k < 144; k++) peek(8'h4F + 8'(k), wd(i, k, rows[i].exp), "msg_word");
      peek(8'h4D, 16'(i + 1), "index");
      peek(8'h49, 16'h0, "count");
      bus(1'b0, mbhs_pkg::REG_MSG_STATUS, 32'h0, rd);
      chk("msg_status", {16'h0, rows[i].exp}, rd);
      bus(1'b1, mbhs_pkg::REG_IRQ_STAT, 32'h1, rd);
      ack(4);
      chk("irq_clear", 32'h0, {31'h0, irq});
      bus(1'b0, mbhs_pkg::REG_IRQ_STAT, 32'h0, rd);
      chk("acked", 32'h2, {29'h0, rd[2:0]});
      bus(1'b1, mbhs_pkg::REG_IRQ_STAT, 32'h2, rd);
    end
    repeat (300) @(posedge core_clk);
    peek(8'h4D, 16'h000C, "idle_index");
    peek(8'h4F, 16'hA00B, "idle_word");
    peek(8'h4E, 16'h0, "word78");
    peek(8'hDF, 16'h0, "word223");
    bus(1'b1, 12'h100, 32'hFFFFFFFF, rd);
    bus(1'b0, 12'h100, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    bus(1'b0, mbhs_pkg::REG_STATE, 32'h0, rd);
    chk("state", 32'h000C_0060, rd);
    bus(1'b0, 12'h400, 32'h0, rd);
    chk("stage_rd", 32'h0000_A008, rd);
    bus(1'b1, mbhs_pkg::REG_IRQ_MASK, 32'h0, rd);
    push_wait(300);
    chk("masked", 32'h0, {31'h0, irq});
    bus(1'b1, mbhs_pkg::REG_IRQ_MASK, 32'h7, rd);
    repeat (3) @(posedge core_clk);
    chk("unmasked", 32'h1, {31'h0, irq});
    bus(1'b1, mbhs_pkg::REG_IRQ_STAT, 32'h7, rd);
    // host not acked: pushes only queue up, fifth is refused
    for (int n = 0; n < 5; n++) bus(1'b1, mbhs_pkg::REG_CTRL, 32'h1, rd);
    repeat (300) @(posedge core_clk);
    peek(8'h49, 16'h4, "queued");
    peek(8'h4D, 16'h000D, "no_ack");
    bus(1'b0, mbhs_pkg::REG_IRQ_STAT, 32'h0, rd);
    chk("refused", 32'h4, {29'h0, rd[2:0]});
    bus(1'b1, mbhs_pkg::REG_IRQ_STAT, 32'h4, rd);
    ack(800);
    peek(8'h4D, 16'h0011, "drained");
    peek(8'h49, 16'h0, "empty");
    bus(1'b0, mbhs_pkg::REG_IRQ_STAT, 32'h0, rd);
    chk("drain_irq", 32'h3, {29'h0, rd[2:0]});
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("rst2", 32'h1, {irq, img_data, avs_waitrequest});
    reset_n <= 1'b1;
    @(posedge core_clk);
    peek(8'h4D, 16'h0, "rst2_index");
    wrap_up();
  end
endmodule // incoming_mailbox_handshake_tb
